// >>> core/pcs_pkg.sv
// Constants and types shared by the program counter and return stack.
// Assumes a single core instruction clock with an active-low asynchronous reset.
package pcs_pkg;

  // ==========================================================================
  // Widths and depths.
  localparam int PCS_PC_W = 13;
  localparam int PCS_HI_W = 5;
  localparam int PCS_PAGE_W = 11;
  localparam int PCS_STACK_DEPTH = 8;
  localparam int PCS_PTR_W = 3;

  // ==========================================================================
  // Field positions and reset values.
  localparam int PCS_LOW_MSB = 7;
  localparam int PCS_PAGE_SEL_LSB = 3;
  localparam logic [12:0] PCS_PC_RESET = 13'h0000;
  localparam logic [4:0] PCS_LATCH_RESET = 5'h00;
  localparam logic [2:0] PCS_PTR_RESET = 3'h0;
  localparam logic [12:0] PCS_PC_STEP = 13'h0001;

  // ==========================================================================
  // Program-counter load sources, one-hot.
  typedef enum logic [4:0] {
    PCS_SRC_INC    = 5'h01,
    PCS_SRC_LOW_WR = 5'h02,
    PCS_SRC_BRANCH = 5'h04,
    PCS_SRC_POP    = 5'h08,
    PCS_SRC_VECTOR = 5'h10
  } pcs_src_t;

endpackage

// >>> core/pcs_stack.sv
// Eight-entry circular return-address store with a hidden pointer.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/1ps
module pcs_stack #(
  parameter int DEPTH = pcs_pkg::PCS_STACK_DEPTH,
  parameter int WIDTH = pcs_pkg::PCS_PC_W
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [WIDTH-1:0] push_data_in,
  output logic [WIDTH-1:0] top_out
);
  import pcs_pkg::*;

  logic [WIDTH-1:0] entry_r [DEPTH];
  logic [PCS_PTR_W-1:0] ptr_r;
  logic [PCS_PTR_W-1:0] ptr_below;

  assign ptr_below = ptr_r - 3'h1;
  // Top of stack is the slot just below the write pointer.
  assign top_out = entry_r[ptr_below];

  // =========================================================================
  // Pointer wraps silently in both directions; nothing flags the wrap.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_r <= PCS_PTR_RESET;
    end else if (push_in) begin
      ptr_r <= ptr_r + 3'h1;
    end else if (pop_in) begin
      ptr_r <= ptr_below;
    end
  end

  // =========================================================================
  // Storage: the ninth push lands on the first slot again.
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          entry_r[i] <= '0;
        end else if (push_in && (ptr_r == PCS_PTR_W'(i))) begin
          entry_r[i] <= push_data_in;
        end
      end
    end
  endgenerate

  chk_push_wraps: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    push_in |=> ptr_r == $past(ptr_r) + 3'h1)
    else $error("stack pointer did not advance on push");
  chk_pop_reads: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (pop_in && !push_in) |=> ptr_r == $past(ptr_r) - 3'h1)
    else $error("stack pointer did not step back on pop");
endmodule

// >>> core/pcs_next_pc.sv
// Selects the next program counter from the active load source.
// Assumes the source is one-hot and the latch is already registered.
`timescale 1ns/1ps
module pcs_next_pc (
  input wire pcs_pkg::pcs_src_t src_in,
  input wire logic [12:0] pc_in,
  input wire logic [7:0] low_data_in,
  input wire logic [4:0] latch_in,
  input wire logic [10:0] target_in,
  input wire logic [12:0] pop_pc_in,
  input wire logic [12:0] vector_in,
  output logic [12:0] next_out
);
  import pcs_pkg::*;

  // =========================================================================
  // Next-PC mux.
  always_comb begin
    case (src_in)
      PCS_SRC_LOW_WR: next_out = {latch_in, low_data_in};
      PCS_SRC_BRANCH: next_out = {latch_in[4:PCS_PAGE_SEL_LSB], target_in};
      PCS_SRC_POP: next_out = pop_pc_in;
      PCS_SRC_VECTOR: next_out = vector_in;
      default: next_out = pc_in + PCS_PC_STEP;
    endcase
  end
endmodule

// >>> core/pcs_top.sv
// Program counter, high latch and return stack of the core.
// Assumes one command strobe per cycle from the instruction decoder.
`timescale 1ns/1ps
module pcs_top #(
  parameter logic [12:0] INT_VECTOR = 13'h0004
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic fetch_in,
  input wire logic low_write_in,
  input wire logic [7:0] low_data_in,
  input wire logic latch_write_in,
  input wire logic [4:0] latch_data_in,
  input wire logic call_in,
  input wire logic jump_in,
  input wire logic [10:0] target_in,
  input wire logic return_in,
  input wire logic return_with_literal_in,
  input wire logic return_from_interrupt_in,
  input wire logic int_entry_in,
  output logic [12:0] pc_out,
  output logic [7:0] pc_low_byte_reg_out,
  output logic [4:0] pc_high_latch_out
);
  import pcs_pkg::*;

  logic [12:0] pc_r;
  logic [12:0] pc_nxt;
  logic [4:0] pc_high_latch_r;
  logic [12:0] stack_top;
  logic push_req;
  logic pop_req;
  logic load_any;
  pcs_src_t src;

  // =========================================================================
  // Stack requests.
  assign push_req = call_in | int_entry_in;
  assign pop_req = return_in | return_with_literal_in | return_from_interrupt_in;
  assign load_any = push_req | pop_req | jump_in | low_write_in;

  // Source priority: interrupt, pop, branch, low-byte write, increment.
  always_comb begin
    if (int_entry_in) begin
      src = PCS_SRC_VECTOR;
    end else if (pop_req) begin
      src = PCS_SRC_POP;
    end else if (call_in || jump_in) begin
      src = PCS_SRC_BRANCH;
    end else if (low_write_in) begin
      src = PCS_SRC_LOW_WR;
    end else begin
      src = PCS_SRC_INC;
    end
  end

  pcs_next_pc u_next (
    .src_in(src),
    .pc_in(pc_r),
    .low_data_in(low_data_in),
    .latch_in(pc_high_latch_r),
    .target_in(target_in),
    .pop_pc_in(stack_top),
    .vector_in(INT_VECTOR),
    .next_out(pc_nxt)
  );

  // The return address is the word after the one being executed.
  pcs_stack u_stack (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .push_in(push_req),
    .pop_in(pop_req && !push_req),
    .push_data_in(pc_r + PCS_PC_STEP),
    .top_out(stack_top)
  );

  // =========================================================================
  // Program counter register; reset clears every bit, upper bits included.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_r <= PCS_PC_RESET;
    end else if (fetch_in || load_any) begin
      pc_r <= pc_nxt;
    end
  end

  // High latch changes only by its own write, never by push or pop.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_high_latch_r <= PCS_LATCH_RESET;
    end else if (latch_write_in) begin
      pc_high_latch_r <= latch_data_in;
    end
  end

  // =========================================================================
  // Software sees only the low byte; the upper bits have no read path.
  assign pc_low_byte_reg_out = pc_r[PCS_LOW_MSB:0];
  assign pc_high_latch_out = pc_high_latch_r;
  assign pc_out = pc_r;

  // =========================================================================
  // Stack fill tracker, used only by the wrap cover below.
  // The hardware itself keeps no such count, so nothing here reaches software;
  // it merely lets a cover see the moment the ninth push overwrites a slot.
  logic [3:0] fill_r;

  // Saturates at the depth on pushes and stops at zero on pops.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_r <= 4'h0;
    end else if (push_req) begin
      if (fill_r != 4'(PCS_STACK_DEPTH)) begin
        fill_r <= fill_r + 4'h1;
      end
    end else if (pop_req) begin
      if (fill_r != 4'h0) begin
        fill_r <= fill_r - 4'h1;
      end
    end
  end

  // =========================================================================
  // Checks.
  // Low-byte write with nothing of higher priority loads latch and data.
  chk_low_write_load: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (low_write_in && !push_req && !pop_req && !jump_in) |=>
      pc_r == {$past(pc_high_latch_r), $past(low_data_in)})
    else $error("low-byte write did not load from latch");

  // A jump takes its page from the two top latch bits.
  chk_branch_page: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (jump_in && !int_entry_in && !pop_req) |=>
      pc_r == {$past(pc_high_latch_r[4:3]), $past(target_in)})
    else $error("branch page wrong");

  // A return right after a call lands on the word after the call.
  chk_call_return: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (call_in && !int_entry_in && !pop_req) ##1 (return_in && !push_req) |=>
      pc_r == $past(pc_r, 2) + 13'h0001)
    else $error("return did not restore call address");

  // Interrupt entry always goes to the vector.
  chk_vector_entry: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    int_entry_in |=> pc_r == INT_VECTOR)
    else $error("interrupt entry missed vector");

  // Stack traffic never disturbs the latch.
  chk_latch_held: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!latch_write_in && (push_req || pop_req)) |=> $stable(pc_high_latch_r))
    else $error("latch changed on stack op");

  // A plain fetch moves one word on.
  chk_inc_step: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fetch_in && !load_any) |=> pc_r == $past(pc_r) + 13'h0001)
    else $error("counter did not advance");

  // With no fetch and no load the counter keeps its value.
  chk_hold_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!fetch_in && !load_any) |=> $stable(pc_r))
    else $error("counter moved while idle");

  // The readable low byte shows what software wrote.
  chk_low_view: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (low_write_in && !push_req && !pop_req && !jump_in) |=>
      pc_low_byte_reg_out == $past(low_data_in))
    else $error("low byte view mismatch");

  // While reset is held the counter sits at zero, upper bits included.
  chk_reset_upper: assert property (@(posedge clock_in)
    !rst_n_in |-> pc_r == PCS_PC_RESET)
    else $error("counter not cleared in reset");

  // While reset is held the latch sits at its reset value.
  chk_latch_reset: assert property (@(posedge clock_in)
    !rst_n_in |-> pc_high_latch_r == PCS_LATCH_RESET)
    else $error("latch not cleared in reset");

  // A latch write puts the written data into the latch on the next cycle.
  chk_latch_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    latch_write_in |=> pc_high_latch_r == $past(latch_data_in))
    else $error("latch write not taken");

  // A call also takes its page from the two top latch bits.
  chk_call_page: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (call_in && !int_entry_in && !pop_req) |=>
      pc_r == {$past(pc_high_latch_r[4:3]), $past(target_in)})
    else $error("call page wrong");

  // Any branch leaves the two top bits equal to the latch page bits.
  chk_page_kept: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ((call_in || jump_in) && !int_entry_in && !pop_req) |=>
      pc_r[12:11] == $past(pc_high_latch_r[4:3]))
    else $error("branch left its page");

  // A pop loads the whole stored counter from the stack top.
  chk_pop_src: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (pop_req && !push_req) |=> pc_r == $past(stack_top))
    else $error("pop did not restore stack top");

  // A push leaves the return address on top of the stack.
  chk_push_ret: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    push_req |=> stack_top == $past(pc_r) + 13'h0001)
    else $error("push stored wrong return address");

  // Return-with-literal after a call also lands after the call.
  chk_rwl_restore: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (call_in && !int_entry_in && !pop_req) ##1 (return_with_literal_in && !push_req) |=>
      pc_r == $past(pc_r, 2) + 13'h0001)
    else $error("literal return did not restore");

  // Return from interrupt lands after the interrupted word.
  chk_rfi_restore: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    int_entry_in ##1 (return_from_interrupt_in && !push_req) |=>
      pc_r == $past(pc_r, 2) + 13'h0001)
    else $error("interrupt return did not restore");

  // The load source decode is always one-hot.
  chk_src_onehot: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $onehot(src))
    else $error("load source not one-hot");

  // =========================================================================
  // Covers for the main scenarios.
  cov_call: cover property (@(posedge clock_in) disable iff (!rst_n_in) call_in ##[1:20] return_in);
  cov_int: cover property (@(posedge clock_in) disable iff (!rst_n_in) int_entry_in ##[1:20] return_from_interrupt_in);
  cov_low: cover property (@(posedge clock_in) disable iff (!rst_n_in) low_write_in);
  cov_wrap: cover property (@(posedge clock_in) disable iff (!rst_n_in) push_req && (fill_r == 4'h8));
  cov_rwl: cover property (@(posedge clock_in) disable iff (!rst_n_in) call_in ##[1:20] return_with_literal_in);
endmodule

// >>> tb/tb.sv
// Self-checking bench for the program counter, high latch and return stack.
// Assumes pcs_pkg and the core files are compiled first; one strobe is driven per cycle, two for interrupt plus return.
`timescale 1ns/1ps
module tb;
  import pcs_pkg::*;
  localparam logic [12:0] VEC = 13'h0004;
  logic clock_in, rst_n_in, fetch_in, low_write_in, latch_write_in, call_in, jump_in;
  logic return_in, return_with_literal_in, return_from_interrupt_in, int_entry_in;
  logic [7:0] low_data_in, pc_low_byte_reg_out;
  logic [4:0] latch_data_in, pc_high_latch_out, m_latch;
  logic [10:0] target_in;
  logic [12:0] pc_out, m_pc;
  logic [12:0] m_stack [8];
  logic [2:0] m_ptr;
  int bad_count, n_checks;

  pcs_top #(.INT_VECTOR(VEC)) dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .fetch_in(fetch_in),
    .low_write_in(low_write_in), .low_data_in(low_data_in), .latch_write_in(latch_write_in),
    .latch_data_in(latch_data_in), .call_in(call_in), .jump_in(jump_in), .target_in(target_in),
    .return_in(return_in), .return_with_literal_in(return_with_literal_in),
    .return_from_interrupt_in(return_from_interrupt_in), .int_entry_in(int_entry_in),
    .pc_out(pc_out), .pc_low_byte_reg_out(pc_low_byte_reg_out), .pc_high_latch_out(pc_high_latch_out));

  // ==========================================================================
  // Clock and watchdog; a hang counts as a mismatch.
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    #(25 * 6000);
    bad_count++;
    finish_test();
  end

  // ==========================================================================
  // Expectations and comparisons.
  function automatic logic [12:0] br_pc(input logic [4:0] lat, input logic [10:0] tgt);
    return {lat[4:3], tgt};
  endfunction
  task automatic check_pc(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected pc at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Operation codes: 0 idle, 1 fetch, 2 low write, 3 latch write, 4 call, 5 jump,
  // 6 return, 7 return with literal, 8 return from interrupt, 9 interrupt, 10 interrupt plus return.
  task automatic drive(input int op, input logic [12:0] d);
    fetch_in = (op == 1);
    low_write_in = (op == 2);
    latch_write_in = (op == 3);
    call_in = (op == 4);
    jump_in = (op == 5);
    return_in = (op == 6 || op == 10);
    return_with_literal_in = (op == 7);
    return_from_interrupt_in = (op == 8);
    int_entry_in = (op == 9 || op == 10);
    low_data_in = d[7:0];
    latch_data_in = d[4:0];
    target_in = d[10:0];
  endtask
  task automatic model(input int op, input logic [12:0] d);
    case (op)
      1: m_pc = m_pc + PCS_PC_STEP;
      2: m_pc = {m_latch, d[7:0]};
      3: m_latch = d[4:0];
      4, 9, 10: begin
        m_stack[m_ptr] = m_pc + PCS_PC_STEP;
        m_ptr = m_ptr + 3'h1;
        m_pc = (op == 4) ? br_pc(m_latch, d[10:0]) : VEC;
      end
      5: m_pc = br_pc(m_latch, d[10:0]);
      6, 7, 8: begin
        m_ptr = m_ptr - 3'h1;
        m_pc = m_stack[m_ptr];
      end
      default: ;
    endcase
  endtask
  // Drives at a falling edge, lets the rising edge act, compares at the next falling edge.
  task automatic step(input int op, input logic [12:0] d);
    drive(op, d);
    @(posedge clock_in);
    model(op, d);
    @(negedge clock_in);
    check_pc(pc_out, m_pc);
    check_byte(pc_low_byte_reg_out, m_pc[7:0]);
    check_byte({3'h0, pc_high_latch_out}, {3'h0, m_latch});
  endtask
  task automatic do_reset(input int n);
    @(negedge clock_in);
    rst_n_in = 1'b0;
    drive(0, 13'h0000);
    repeat (n) @(negedge clock_in);
    m_pc = PCS_PC_RESET;
    m_latch = PCS_LATCH_RESET;
    m_ptr = PCS_PTR_RESET;
    foreach (m_stack[i]) m_stack[i] = 13'h0000;
    check_pc(pc_out, m_pc);
    check_byte({3'h0, pc_high_latch_out}, 8'h00);
    rst_n_in = 1'b1;
  endtask

  // ==========================================================================
  // Main sequence: corner cases first, then random traffic and a reset in mid-run.
  initial begin
    rst_n_in = 1'b0;
    drive(0, 13'h0000);
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'h8ff2));
    do_reset(8);
    step(3, 13'h001b);
    step(2, 13'h00ff);
    step(1, 13'h0000);
    step(2, {5'h00, m_pc[7:0] + 8'hf0});
    for (int i = 0; i < 10; i++) begin
      step(3, 13'(i * 3));
      step(4, 13'(i * 171 + 7));
    end
    for (int i = 0; i < 10; i++) step(6 + (i % 3), 13'h0000);
    step(9, 13'h0000);
    step(10, 13'h0000);
    step(8, 13'h0000);
    step(5, 13'h07ff);
    for (int i = 0; i < 2000; i++) step($urandom_range(0, 10), 13'($urandom));
    do_reset(2);
    for (int i = 0; i < 200; i++) step($urandom_range(0, 10), 13'($urandom));
    finish_test();
  end
endmodule
